// ===== hdl/i2c_slv_pkg.sv
// shared constants and types for the serial bus slave
package i2c_slv_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 4;                 // mclk_i period

    // least time: round up, never below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    // longest or nominal time: round down, never below one cycle
    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_dn

    localparam int FILT_HS_NS = 10;            // spike rejection, high-speed
    localparam int FILT_FS_NS = 50;            // spike rejection, fast mode
    localparam int DLY_HS_NS  = 80;            // sda hold delay, high-speed
    localparam int DLY_FS_NS  = 120;           // sda hold delay, fast mode

    localparam int FILT_W = 4;
    localparam logic [FILT_W-1:0] FILT_HS_CYC = FILT_W'(cyc_up(FILT_HS_NS));
    localparam logic [FILT_W-1:0] FILT_FS_CYC = FILT_W'(cyc_up(FILT_FS_NS));
    localparam int DLY_HS_CYC = cyc_dn(DLY_HS_NS);
    localparam int DLY_FS_CYC = cyc_dn(DLY_FS_NS);

    // ----------------------------------------------------------------
    // protocol constants
    // ----------------------------------------------------------------
    localparam logic [7:0] DEF_ADDR_WR = 8'h80;     // default address, write form
    localparam logic [4:0] MCODE_PFX   = 5'h01;     // master code 0000_1xxx
    localparam logic [3:0] BIT_LAST    = 4'h7;      // count before 8th data bit
    localparam logic [3:0] BIT_ACK     = 4'h8;      // all data bits taken
    localparam logic [7:0] PTR_STEP    = 8'h01;
    localparam logic [7:0] PTR_RST     = 8'h00;
    localparam logic [7:0] RD_ZERO     = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,     // bus free, after reset or stop
        S_ADDR,     // taking slave address byte
        S_PTR,      // taking register pointer byte
        S_WDATA,    // taking data bytes
        S_RDATA,    // sending data bytes
        S_SKIP      // ignore until start or stop
    } state_e;

    // register access request toward the register file
    typedef struct packed {
        logic [7:0] addr;   // current pointer
        logic [7:0] wdata;  // byte written
        logic       wr;     // write strobe, one cycle
        logic       rd;     // read strobe, one cycle
    } reg_req_s;

endpackage : i2c_slv_pkg

// ===== hdl/i2c_line_filter.sv
// spike filter for one bus line with selectable rejection width
`timescale 1ns/1ns
`default_nettype none
module i2c_line_filter (
    input  wire logic                         mclk_i,  // system clock
    input  wire logic                         srst_i,  // sync reset
    input  wire logic                         din_i,   // synchronised line
    input  wire logic [i2c_slv_pkg::FILT_W-1:0] thr_i, // reject width, cycles
    output logic                              dout_o   // filtered line
);
    import i2c_slv_pkg::*;

    logic [FILT_W-1:0] cnt_reg;
    logic              dout_reg;

    // output follows only after the input differs for more than thr cycles
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_reg  <= '0;
            dout_reg <= 1'b1;
        end else if (din_i == dout_reg) begin
            cnt_reg  <= '0;
        end else if (cnt_reg >= thr_i) begin
            cnt_reg  <= '0;
            dout_reg <= din_i;
        end else begin
            cnt_reg  <= cnt_reg + FILT_W'(1);
        end
    end

    assign dout_o = dout_reg;

endmodule : i2c_line_filter
`default_nettype wire

// ===== hdl/i2c_slave_regacc.sv
// serial bus slave with auto-incrementing register pointer
// Operation
// - pointer steps by one after every data byte, valid location or not
// - pointer byte naming unimplemented location is not acked, transfer continues
// - read of unimplemented location returns zero byte, pointer still steps
// - reads and writes run over the whole range, pointer wraps
// - writes to unimplemented location dropped and not acked, valid ones stored
// - sda fall while scl high is start, sda rise while scl high stop
// - sda changes only while scl low, one clock pulse per bit
// - bytes are eight bits msb first, ninth bit is receiver acknowledge
// - acknowledging party holds sda low across the whole ack high phase
// - master nack ends read, slave releases sda for stop
// - first byte is 7-bit address plus direction, acked on match
// - own address comes from otp, default write form 80h
// - first write byte loads pointer, later bytes are data
// - read starts at current pointer, left from earlier access
// - any number of bytes between start and stop, no own limit
// - repeated start ends transfer and begins a new one at once
// - master code never acked, switches to high-speed settings
// - stay high-speed until stop, then back to fast settings
// - input spike filter rejects 10ns in high-speed, 50ns in fast
// - sda hold delay for start/stop 80ns high-speed, longer in fast
// - sda start/stop delay 120ns in fast mode, below start hold limit
// - slave only, never holds scl low
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_regacc (
    input  wire logic                    mclk_i,       // system clock 250 MHz
    input  wire logic                    srst_i,       // sync reset, active high
    input  wire logic                    scl_i,        // bus clock pin, input only
    input  wire logic                    sda_i,        // bus data pin level
    output logic                         sda_o,        // bus data drive value
    output logic                         sda_oe_o,     // bus data drive enable
    input  wire logic [6:0]              otp_addr_i,   // programmed own address
    input  wire logic                    otp_valid_i,  // programmed address present
    input  wire logic                    reg_valid_i,  // pointer names implemented reg
    input  wire logic [7:0]              rd_data_i,    // data at pointer
    output i2c_slv_pkg::reg_req_s        reg_req_o,    // register access request
    output logic                         hs_mode_o     // high-speed settings active
);
    import i2c_slv_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers, filters and sda hold delay
    // ----------------------------------------------------------------
    logic [1:0]            scl_sync_reg;
    logic [1:0]            sda_sync_reg;
    logic                  scl_f;
    logic                  sda_f;
    logic                  hs_reg;
    logic [FILT_W-1:0]     filt_thr;
    logic [DLY_FS_CYC-1:0] dly_reg;
    logic                  sda_d;

    // two flops before any logic looks at the pins
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
        end
    end

    assign filt_thr = hs_reg ? FILT_HS_CYC : FILT_FS_CYC;

    i2c_line_filter u_scl_filt (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .din_i  (scl_sync_reg[1]),
        .thr_i  (filt_thr),
        .dout_o (scl_f)
    );

    i2c_line_filter u_sda_filt (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .din_i  (sda_sync_reg[1]),
        .thr_i  (filt_thr),
        .dout_o (sda_f)
    );

    // delay line bridging the scl fall before start/stop detection
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dly_reg <= '1;
        end else begin
            dly_reg <= {dly_reg[DLY_FS_CYC-2:0], sda_f};
        end
    end

    assign sda_d = hs_reg ? dly_reg[DLY_HS_CYC-1] : dly_reg[DLY_FS_CYC-1];

    // ----------------------------------------------------------------
    // bus event detection
    // ----------------------------------------------------------------
    logic scl_q_reg;
    logic sda_d_q_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            scl_q_reg   <= 1'b1;
            sda_d_q_reg <= 1'b1;
        end else begin
            scl_q_reg   <= scl_f;
            sda_d_q_reg <= sda_d;
        end
    end

    assign scl_rise  = scl_f & ~scl_q_reg;
    assign scl_fall  = ~scl_f & scl_q_reg;
    // edges of delayed sda with scl high both cycles
    assign start_det = scl_f & scl_q_reg & sda_d_q_reg & ~sda_d;
    assign stop_det  = scl_f & scl_q_reg & ~sda_d_q_reg & sda_d;

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    state_e     state_reg;
    logic [3:0] bit_cnt_reg;     // rises taken in current byte
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] ptr_reg;
    logic [7:0] wdata_reg;
    logic       ack_ok_reg;      // ack decided at byte end
    logic       chk_valid_reg;   // ack depends on new pointer
    logic       ack_slot_reg;    // inside ninth bit low/high phase
    logic       tx_slot_reg;     // master acks this slot
    logic       data_byte_reg;   // slot follows a data byte
    logic       wr_stb_reg;
    logic       rd_stb_reg;
    logic       sda_oe_reg;
    logic [7:0] rx_byte;
    logic [6:0] own_addr;

    assign rx_byte  = {rx_shift_reg[6:0], sda_f};
    assign own_addr = otp_valid_i ? otp_addr_i : DEF_ADDR_WR[7:1];

    // byte framing, addressing, pointer and acknowledge handling
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg     <= S_IDLE;
            bit_cnt_reg   <= '0;
            rx_shift_reg  <= '0;
            tx_shift_reg  <= '0;
            ptr_reg       <= PTR_RST;
            wdata_reg     <= '0;
            ack_ok_reg    <= 1'b0;
            chk_valid_reg <= 1'b0;
            ack_slot_reg  <= 1'b0;
            tx_slot_reg   <= 1'b0;
            data_byte_reg <= 1'b0;
            wr_stb_reg    <= 1'b0;
            rd_stb_reg    <= 1'b0;
            sda_oe_reg    <= 1'b0;
        end else begin
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            if (stop_det) begin
                state_reg    <= S_IDLE;
                sda_oe_reg   <= 1'b0;
                ack_slot_reg <= 1'b0;
            end else if (start_det) begin
                // repeated start restarts framing; pointer is kept
                state_reg    <= S_ADDR;
                bit_cnt_reg  <= '0;
                sda_oe_reg   <= 1'b0;
                ack_slot_reg <= 1'b0;
            end else if (state_reg != S_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt_reg != BIT_ACK) begin
                        rx_shift_reg <= rx_byte;
                        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                    end else begin
                        // ninth bit: master answer on sent data
                        bit_cnt_reg <= '0;
                        if (data_byte_reg) begin
                            ptr_reg <= ptr_reg + PTR_STEP;
                        end
                        if (tx_slot_reg && sda_f) begin
                            state_reg <= S_SKIP;
                        end
                    end
                    if (bit_cnt_reg == BIT_LAST) begin
                        ack_ok_reg    <= 1'b0;
                        chk_valid_reg <= 1'b0;
                        tx_slot_reg   <= (state_reg == S_RDATA);
                        data_byte_reg <= (state_reg == S_RDATA) || (state_reg == S_WDATA);
                        case (state_reg)
                            S_ADDR: begin
                                if (rx_byte[7:3] == MCODE_PFX) begin
                                    state_reg <= S_SKIP;
                                end else if (rx_byte[7:1] == own_addr) begin
                                    ack_ok_reg <= 1'b1;
                                    state_reg  <= rx_byte[0] ? S_RDATA : S_PTR;
                                end else begin
                                    state_reg <= S_SKIP;
                                end
                            end
                            S_PTR: begin
                                ptr_reg       <= rx_byte;
                                chk_valid_reg <= 1'b1;
                                state_reg     <= S_WDATA;
                            end
                            S_WDATA: begin
                                wdata_reg  <= rx_byte;
                                ack_ok_reg <= reg_valid_i;
                                wr_stb_reg <= reg_valid_i;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (scl_fall) begin
                    if (bit_cnt_reg == BIT_ACK && !ack_slot_reg) begin
                        // enter ninth bit: ack as receiver, release as sender
                        ack_slot_reg <= 1'b1;
                        sda_oe_reg   <= !tx_slot_reg &&
                                        (ack_ok_reg || (chk_valid_reg && reg_valid_i));
                    end else if (ack_slot_reg) begin
                        ack_slot_reg <= 1'b0;
                        sda_oe_reg   <= 1'b0;
                        if (state_reg == S_RDATA) begin
                            // load byte at pointer, zero if unimplemented
                            tx_shift_reg <= reg_valid_i ? rd_data_i : RD_ZERO;
                            sda_oe_reg   <= reg_valid_i ? ~rd_data_i[7] : 1'b1;
                            rd_stb_reg   <= 1'b1;
                        end
                    end else if (state_reg == S_RDATA && bit_cnt_reg != '0) begin
                        // next bit only while scl low
                        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        sda_oe_reg   <= ~tx_shift_reg[6];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // speed mode tracking
    // ----------------------------------------------------------------
    // master code selects high-speed, only stop returns to fast
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hs_reg <= 1'b0;
        end else if (stop_det) begin
            hs_reg <= 1'b0;
        end else if (scl_rise && state_reg == S_ADDR && bit_cnt_reg == BIT_LAST
                     && rx_byte[7:3] == MCODE_PFX) begin
            hs_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // open-drain data: only ever pulls low; scl is never driven
    assign sda_o           = 1'b0;
    assign sda_oe_o        = sda_oe_reg;
    assign hs_mode_o       = hs_reg;
    assign reg_req_o.addr  = ptr_reg;
    assign reg_req_o.wdata = wdata_reg;
    assign reg_req_o.wr    = wr_stb_reg;
    assign reg_req_o.rd    = rd_stb_reg;

endmodule : i2c_slave_regacc
`default_nettype wire

// ===== verif/i2c_slave_regacc_assertions.sv
// concurrent checks on the serial bus slave ports
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_regacc_assertions (
    input wire logic                  mclk_i,      // system clock
    input wire logic                  srst_i,      // sync reset
    input wire logic                  scl_i,       // bus clock pin
    input wire logic                  sda_i,       // bus data level
    input wire logic                  sda_o,       // data drive value
    input wire logic                  sda_oe_o,    // data drive enable
    input wire logic [6:0]            otp_addr_i,  // own address
    input wire logic                  otp_valid_i, // own address present
    input wire logic                  reg_valid_i, // implemented location
    input wire logic [7:0]            rd_data_i,   // read data
    input wire i2c_slv_pkg::reg_req_s reg_req_o,   // access request
    input wire logic                  hs_mode_o    // high-speed settings
);
    import i2c_slv_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    logic [7:0] wa_reg; // pointer at last store
    logic [7:0] ra_reg; // pointer at last load
    // capture the pointer at each strobe
    always_ff @(posedge mclk_i) begin
        if (reg_req_o.wr) wa_reg <= reg_req_o.addr;
        if (reg_req_o.rd) ra_reg <= reg_req_o.addr;
    end
    property p_drv_zero; sda_o == 1'b0; endproperty
    a_drv_zero: assert property (p_drv_zero) else $error("drive value not low");
    property p_oe_low; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
    property p_wr_once; reg_req_o.wr |=> !reg_req_o.wr; endproperty
    a_wr_once: assert property (p_wr_once) else $error("store strobe too long");
    property p_wr_valid; reg_req_o.wr |-> reg_valid_i; endproperty
    a_wr_valid: assert property (p_wr_valid) else $error("store at bad location");
    property p_wr_step;
        reg_req_o.wr |-> ##[50:200] reg_req_o.addr == wa_reg + PTR_STEP;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("no step after store");
    property p_rd_step;
        reg_req_o.rd |-> ##[700:1000] reg_req_o.addr == ra_reg + PTR_STEP;
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("no step after load");
    property p_excl; !(reg_req_o.wr && reg_req_o.rd); endproperty
    a_excl: assert property (p_excl) else $error("store and load together");
    property p_hs_exit; scl_i && $rose(sda_i) && hs_mode_o |-> ##[1:125] !hs_mode_o; endproperty
    a_hs_exit: assert property (p_hs_exit) else $error("high-speed kept after stop");
    property p_rst;
        $fell(srst_i) |-> !sda_oe_o && !hs_mode_o && reg_req_o.addr == PTR_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    c_wr: cover property (reg_req_o.wr);
    c_rd: cover property (reg_req_o.rd);
    c_hs: cover property ($rose(hs_mode_o));
endmodule : i2c_slave_regacc_assertions
bind i2c_slave_regacc i2c_slave_regacc_assertions u_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .otp_addr_i(otp_addr_i), .otp_valid_i(otp_valid_i),
    .reg_valid_i(reg_valid_i), .rd_data_i(rd_data_i), .reg_req_o(reg_req_o),
    .hs_mode_o(hs_mode_o)
);
`default_nettype wire

// ===== verif/i2c_host_model.sv
// bus master model that makes the link clock and drives data
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    input  wire logic mclk_i,    // system clock
    input  wire logic sda_i,     // data wire level
    output logic      scl_o,     // link clock, still high between frames
    output logic      sda_low_o  // 1 pulls data low
);
    int spike = 0; // scl glitch width in cycles inside each low phase, 0 for none
    // idle bus at time zero
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // wait whole system clock cycles
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tk
    // one bit: data moves early in the low phase, sampled mid high
    task automatic bit_x(input logic v, output logic s);
        tk(5);
        sda_low_o <= !v;
        tk(25);
        // optional short scl glitch that the input filter must swallow
        if (spike > 0) begin
            scl_o <= 1'b1;
            tk(spike);
            scl_o <= 1'b0;
        end
        tk(30 - spike);
        scl_o <= 1'b1;
        tk(20);
        s = sda_i;
        tk(20);
        scl_o <= 1'b0;
    endtask : bit_x
    // start from idle or repeated start from clock low
    task automatic start();
        tk(20);
        sda_low_o <= 1'b0;
        tk(50);
        scl_o <= 1'b1;
        tk(50);
        sda_low_o <= 1'b1;
        tk(50);
        scl_o <= 1'b0;
    endtask : start
    // stop, then bus free time
    task automatic stop();
        tk(5);
        sda_low_o <= 1'b1;
        tk(55);
        scl_o <= 1'b1;
        tk(50);
        sda_low_o <= 1'b0;
        tk(130);
    endtask : stop
    // byte out msb first, ninth bit returns the acknowledge level
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, ack_n);
    endtask : put_byte
    // byte in msb first, then acknowledge or withhold it
    task automatic get_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(nack, s);
    endtask : get_byte
endmodule : i2c_host_model
`default_nettype wire

// ===== verif/i2c_slave_regacc_tb_top.sv
// self-checking bench for the serial bus slave
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_regacc_tb_top;
    import i2c_slv_pkg::*;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [6:0]  otp_a  = 7'h00;
    logic        otp_v  = 1'b0;
    logic        scl, hlow, sda_oe, sda_drv, hs, vld;
    wire logic   sda_w;
    reg_req_s    req;
    logic [7:0]  regs [256];
    logic [7:0]  expm [256];
    logic [7:0]  ptr;                 // expected pointer
    logic [31:0] rng = 32'h44550210;
    int          fails = 0;
    int          compares = 0;
    // clock and pulled-up data wire
    initial forever #2 mclk_i = ~mclk_i;
    assign sda_w = !(sda_oe || hlow);
    assign vld = impl(req.addr);
    i2c_slave_regacc u_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv),
        .sda_oe_o(sda_oe), .otp_addr_i(otp_a), .otp_valid_i(otp_v), .reg_valid_i(vld),
        .rd_data_i(regs[req.addr]), .reg_req_o(req), .hs_mode_o(hs)
    );
    i2c_host_model u_host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(hlow));
    // register file beside the block
    always @(posedge mclk_i) begin
        if (req.wr === 1'b1) regs[req.addr] <= req.wdata;
    end
    function automatic logic impl(input logic [7:0] a);
        return (a[7:4] == 4'h1) || (a >= 8'hFC);
    endfunction : impl
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return impl(a) ? expm[a] : RD_ZERO;
    endfunction : exp_rd
    function logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : next_rand
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // pointer write then data bytes
    task automatic wr_seq(input logic [7:0] aw, input logic [7:0] p, input int n);
        logic a;
        logic [7:0] d;
        u_host.start();
        u_host.put_byte(aw, a);
        chk("addr ack", {7'h0, a}, 8'h00);
        u_host.put_byte(p, a);
        ptr = p;
        chk("ptr ack", {7'h0, a}, {7'h0, !impl(p)});
        for (int k = 0; k < n; k++) begin
            d = 8'(next_rand());
            u_host.put_byte(d, a);
            chk("data ack", {7'h0, a}, {7'h0, !impl(ptr)});
            if (impl(ptr)) expm[ptr] = d;
            ptr = ptr + PTR_STEP;
        end
        u_host.stop();
    endtask : wr_seq
    // optional pointer write, repeated start, then read bytes
    task automatic rd_seq(input logic [7:0] aw, input logic setp, input logic [7:0] p,
                          input int n);
        logic a;
        logic [7:0] d;
        if (setp) begin
            u_host.start();
            u_host.put_byte(aw, a);
            u_host.put_byte(p, a);
            ptr = p;
        end
        u_host.start();
        u_host.put_byte(aw | 8'h01, a);
        chk("rd addr ack", {7'h0, a}, 8'h00);
        for (int k = 0; k < n; k++) begin
            u_host.get_byte(k == n - 1, d);
            chk("rd data", d, exp_rd(ptr));
            ptr = ptr + PTR_STEP;
        end
        u_host.stop();
    endtask : rd_seq
    task automatic wrap_up();
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // watchdog
    initial begin
        repeat (100000) @(posedge mclk_i);
        fails++;
        wrap_up();
    end
    // main sequence
    initial begin
        logic a;
        logic [7:0] p;
        for (int i = 0; i < 256; i++) begin
            regs[i] = ~i[7:0];
            expm[i] = ~i[7:0];
        end
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (40) @(posedge mclk_i);
        // fast-mode scl glitches of 40 ns must not count as clock pulses
        u_host.spike = 10;
        wr_seq(DEF_ADDR_WR, 8'h1E, 3);
        wr_seq(DEF_ADDR_WR, 8'h0E, 3);
        wr_seq(DEF_ADDR_WR, 8'hFE, 3);
        rd_seq(DEF_ADDR_WR, 1'b1, 8'h1E, 3);
        rd_seq(DEF_ADDR_WR, 1'b1, 8'hFD, 4);
        u_host.spike = 0;
        rd_seq(DEF_ADDR_WR, 1'b0, 8'h00, 2);
        // foreign address, then master code; neither is acknowledged
        u_host.start();
        u_host.put_byte(8'h90, a);
        chk("foreign ack", {7'h0, a}, 8'h01);
        u_host.put_byte(8'h10, a);
        chk("skip ack", {7'h0, a}, 8'h01);
        u_host.start();
        u_host.put_byte(8'h08, a);
        chk("mcode ack", {7'h0, a}, 8'h01);
        chk("hs on", {7'h0, hs}, 8'h01);
        // high-speed scl glitches of 8 ns must be swallowed as well
        u_host.spike = 2;
        wr_seq(DEF_ADDR_WR, 8'h12, 2);
        u_host.spike = 0;
        chk("hs off", {7'h0, hs}, 8'h00);
        for (int r = 0; r < 4; r++) begin
            p = {4'h1, 4'(next_rand())};
            wr_seq(DEF_ADDR_WR, p, 2);
            rd_seq(DEF_ADDR_WR, 1'b1, p, 2);
        end
        // second reset with a programmed own address
        srst_i <= 1'b1;
        otp_a <= {3'h5, 4'(next_rand())};
        otp_v <= 1'b1;
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (40) @(posedge mclk_i);
        u_host.start();
        u_host.put_byte(DEF_ADDR_WR, a);
        chk("old addr ack", {7'h0, a}, 8'h01);
        u_host.stop();
        wr_seq({otp_a, 1'b0}, 8'h1F, 1);
        rd_seq({otp_a, 1'b0}, 1'b0, 8'h00, 1);
        wrap_up();
    end
endmodule : i2c_slave_regacc_tb_top
`default_nettype wire
